// ### verilog/init_config_and_mode_select.v
// spi-reached init setup register and secured mode-select register
`timescale 1ns/10ps
`include "init_cfg_defs.vh"

module init_config_and_mode_select #(
  parameter INT_LONG_CYC  = `INT_LONG_CYC,     // long interrupt pulse in cycles
  parameter INT_SHORT_CYC = `INT_SHORT_CYC     // short interrupt pulse in cycles
) (
  input  wire       ref_clk,                   // 250 mhz device clock
  input  wire       rst,                       // synchronous reset, active high
  input  wire       spi_sclk,                  // spi clock pin from host
  input  wire       spi_mosi,                  // spi data in pin
  input  wire       spi_cs_n,                  // spi chip select pin, active low
  output reg        spi_miso,                  // spi data out
  output reg        spi_miso_oe_n,             // low while driving miso
  input  wire [2:0] dev_mode,                  // current device mode
  input  wire       lp_req,                    // low-power entry request pulse
  input  wire [2:0] lp_code,                   // inverted random bits 2..0 from mode register
  output reg        lp_grant,                  // low-power entry accepted pulse
  output reg        lp_deny,                   // low-power entry refused pulse
  input  wire       wd_half,                   // half watchdog period reached pulse
  input  wire       int_event,                 // interrupt event pulse
  input  wire       int_ack,                   // interrupt flags read, release level
  input  wire [1:0] res_detect,                // resistor variant seen at config pin
  input  wire       flag_clr,                  // clear debug-resistor flag
  output reg        mode_req,                  // accepted secured mode change pulse
  output reg  [1:0] mode_req_sel,              // target mode of that change
  output reg        safe_n,                    // fail-safe output, active low
  output reg  [1:0] failsafe_variant,          // variant in force
  output reg        failsafe_override,         // variant comes from register
  output reg        dbg_res_flag,              // debug-resistor mismatch flag
  output reg        parity_err,                // parity error on last write
  output reg        int_n                      // interrupt output, active low
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam [2:0] PIN_IDLE_LVL = `PIN_IDLE;   // cs_n high, mosi and sclk low
  wire [2:0]  pin_reg;                         // filtered sclk, mosi, cs_n
  wire [2:0]  pin_prev_reg;                    // filtered pins one cycle back
  reg  [4:0]  bit_cnt_reg;
  reg  [15:0] shift_reg;
  reg  [7:0]  miso_sh_reg;
  reg  [7:0]  init_misc_setup_reg;
  reg  [7:0]  secured_mode_select_reg;
  reg  [5:0]  lfsr_reg;
  reg  [5:0]  rnd_reg;                         // last issued random code
  reg         rnd_valid_reg;
  reg  [14:0] int_cnt_reg;
  reg  [14:0] int_cnt_next;
  reg         int_hold_reg;
  reg         int_hold_next;
  wire [2:0]  pin_raw;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_fall;
  wire        cs_rise;
  wire        cs_active;
  wire [7:0]  first_byte;
  wire [1:0]  f_cmd;
  wire [4:0]  f_addr;
  wire [7:0]  f_data;
  wire        frame_done;
  wire        parity_ok;
  wire        wr_misc;
  wire        wr_mode;
  wire        code_inv;
  wire        code_safe;
  wire        mode_ok;
  wire        int_fire;

  // code matches the inverse of the random code in the masked bits
  function inv_match;
    input [5:0] code;
    input [5:0] rnd;
    input [5:0] mask;
    begin
      inv_match = ((code ^ rnd) & mask) == mask;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {spi_cs_n, spi_mosi, spi_sclk};

  // three flops per pin, a change counts once second and third agree;
  // reset to the idle level so no false edge follows reset
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg [2:0] sync_reg;                      // first, second, third flop
      reg       filt_reg;                      // filtered level
      reg       filt_prev_reg;                 // filtered level one cycle back
      always @(posedge ref_clk) begin
        if (rst) begin
          sync_reg      <= {3{PIN_IDLE_LVL[gi]}};
          filt_reg      <= PIN_IDLE_LVL[gi];
          filt_prev_reg <= PIN_IDLE_LVL[gi];
        end else begin
          sync_reg <= {sync_reg[1:0], pin_raw[gi]};
          if (sync_reg[1] == sync_reg[2]) begin
            filt_reg <= sync_reg[2];
          end
          filt_prev_reg <= filt_reg;
        end
      end
      assign pin_reg[gi]      = filt_reg;
      assign pin_prev_reg[gi] = filt_prev_reg;
    end
  endgenerate

  assign sclk_rise = pin_reg[0] & ~pin_prev_reg[0];
  assign sclk_fall = ~pin_reg[0] & pin_prev_reg[0];
  assign cs_fall   = ~pin_reg[2] & pin_prev_reg[2];
  assign cs_rise   = pin_reg[2] & ~pin_prev_reg[2];
  assign cs_active = ~pin_reg[2];

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  assign first_byte = {shift_reg[6:0], pin_reg[1]};
  assign f_cmd      = shift_reg[15:14];
  assign f_addr     = shift_reg[13:9];
  assign f_data     = shift_reg[7:0];
  assign frame_done = cs_rise && (bit_cnt_reg == `FRAME_BITS) && (f_cmd == `CMD_WRITE);
  // even parity over all sixteen bits, checked only when enabled
  assign parity_ok  = ~init_misc_setup_reg[`MISC_PARITY_EN] | ~(^shift_reg);
  assign wr_misc    = frame_done && parity_ok && (f_addr == `ADDR_MISC)
                      && (dev_mode == `DEV_INIT);
  assign wr_mode    = frame_done && parity_ok && (f_addr == `ADDR_MODE);
  assign code_inv   = rnd_valid_reg && inv_match(f_data[5:0], rnd_reg, 6'h3f);
  assign code_safe  = rnd_valid_reg && inv_match(f_data[5:0], rnd_reg, 6'h0f)
                      && (f_data[5:4] == rnd_reg[5:4]);
  // target codes and the mode each may be entered from
  assign mode_ok    = (f_data[7:6] == `SEL_RESET) || (f_data[7:6] == `SEL_REPROG)
                      || ((f_data[7:6] == `SEL_INIT) && (dev_mode == `DEV_NORMAL));

  // ----------------------------------------------------------------
  // spi shifting and read answers
  // ----------------------------------------------------------------
  // mode 0: capture on sclk rise, present on sclk fall, answer in second byte
  always @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt_reg   <= 5'h00;
      shift_reg     <= 16'h0000;
      miso_sh_reg   <= 8'h00;
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso_oe_n <= ~cs_active;
      if (cs_fall) begin
        bit_cnt_reg <= 5'h00;
        shift_reg   <= 16'h0000;
        spi_miso    <= 1'b0;
      end else if (cs_active && sclk_rise && bit_cnt_reg != `FRAME_BITS) begin
        shift_reg   <= {shift_reg[14:0], pin_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == `FIRST_BYTE_BITS - 5'h01) begin
          if (first_byte[5:1] == `ADDR_MISC) begin
            miso_sh_reg <= init_misc_setup_reg;
          end else if (first_byte[5:1] == `ADDR_MODE) begin
            miso_sh_reg <= {secured_mode_select_reg[7:6], lfsr_reg};
          end else begin
            miso_sh_reg <= 8'h00;
          end
        end
      end else if (cs_active && sclk_fall && bit_cnt_reg >= `FIRST_BYTE_BITS
                   && bit_cnt_reg != `FRAME_BITS) begin
        spi_miso    <= miso_sh_reg[7];
        miso_sh_reg <= {miso_sh_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // registers, random code and secured mode change
  // ----------------------------------------------------------------
  // free-running code source, latched when the mode register is read
  always @(posedge ref_clk) begin
    if (rst) begin
      lfsr_reg                <= `LFSR_SEED;
      rnd_reg                 <= 6'h00;
      rnd_valid_reg           <= 1'b0;
      init_misc_setup_reg     <= `MISC_RESET;
      secured_mode_select_reg <= `MODE_RESET;
      mode_req                <= 1'b0;
      mode_req_sel            <= 2'h0;
      safe_n                  <= 1'b1;
      parity_err              <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[4:0], lfsr_reg[5] ^ lfsr_reg[4]};
      mode_req <= 1'b0;
      if (cs_active && sclk_rise && bit_cnt_reg == `FIRST_BYTE_BITS - 5'h01
          && first_byte[7:6] == `CMD_READ && first_byte[5:1] == `ADDR_MODE) begin
        rnd_reg       <= lfsr_reg;
        rnd_valid_reg <= 1'b1;
      end else if (wr_mode) begin
        rnd_valid_reg <= 1'b0;
      end
      if (frame_done) begin
        parity_err <= ~parity_ok;
      end
      if (wr_misc) begin
        init_misc_setup_reg <= f_data;
      end
      // full inverse changes mode; split code from init drives fail-safe low
      if (wr_mode && code_inv && mode_ok) begin
        secured_mode_select_reg <= f_data;
        mode_req                <= 1'b1;
        mode_req_sel            <= f_data[7:6];
      end else if (wr_mode && code_safe && f_data[7:6] == `SEL_INIT
                   && dev_mode == `DEV_INIT) begin
        secured_mode_select_reg <= f_data;
        safe_n                  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // low-power entry check
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      lp_grant <= 1'b0;
      lp_deny  <= 1'b0;
    end else begin
      lp_grant <= lp_req && (~init_misc_setup_reg[`MISC_RND_GATE]
                  || (rnd_valid_reg && inv_match({3'h0, lp_code}, rnd_reg, 6'h07)));
      lp_deny  <= lp_req && init_misc_setup_reg[`MISC_RND_GATE]
                  && ~(rnd_valid_reg && inv_match({3'h0, lp_code}, rnd_reg, 6'h07));
    end
  end

  // ----------------------------------------------------------------
  // debug resistor and fail-safe variant
  // ----------------------------------------------------------------
  // field low bits 00 b3, 01 b2, 10 b1, 11 a; same coding as res_detect
  always @(posedge ref_clk) begin
    if (rst) begin
      dbg_res_flag      <= 1'b0;
      failsafe_variant  <= 2'h0;
      failsafe_override <= 1'b0;
    end else begin
      if (init_misc_setup_reg[`MISC_DBG_EN]
          && res_detect != init_misc_setup_reg[1:0]) begin
        dbg_res_flag <= 1'b1;
      end else if (flag_clr) begin
        dbg_res_flag <= 1'b0;
      end
      failsafe_override <= init_misc_setup_reg[`MISC_DBG_EN];
      failsafe_variant  <= init_misc_setup_reg[`MISC_DBG_EN] ?
                           init_misc_setup_reg[1:0] : res_detect;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output shaping
  // ----------------------------------------------------------------
  assign int_fire = int_event || (wd_half && init_misc_setup_reg[`MISC_INT_HALF]
                    && dev_mode == `DEV_REPROG);

  // pulse counter or held level; a new event wins over the release
  always @* begin
    int_cnt_next  = int_cnt_reg;
    int_hold_next = int_hold_reg;
    if (int_fire && ~init_misc_setup_reg[`MISC_INT_LEVEL]) begin
      int_cnt_next = init_misc_setup_reg[`MISC_INT_WIDTH] ?
                     INT_SHORT_CYC[14:0] : INT_LONG_CYC[14:0];
    end else if (int_cnt_reg != 15'h0000) begin
      int_cnt_next = int_cnt_reg - 15'h0001;
    end
    if (int_fire && init_misc_setup_reg[`MISC_INT_LEVEL]) begin
      int_hold_next = 1'b1;
    end else if (int_ack) begin
      int_hold_next = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      int_cnt_reg  <= 15'h0000;
      int_hold_reg <= 1'b0;
      int_n        <= 1'b1;
    end else begin
      int_cnt_reg  <= int_cnt_next;
      int_hold_reg <= int_hold_next;
      int_n        <= ~(int_hold_next || int_cnt_next != 15'h0000);
    end
  end

endmodule // init_config_and_mode_select

// ### pkg/init_cfg_defs.vh
// constants for the init-setup and secured-mode register bank
`ifndef INIT_CFG_DEFS_VH
`define INIT_CFG_DEFS_VH

// ----------------------------------------------------------------
// frame fields and register addresses
// ----------------------------------------------------------------
`define CMD_READ         2'h0
`define CMD_WRITE        2'h1
`define ADDR_MISC        5'h08
`define ADDR_MODE        5'h09
`define FRAME_BITS       5'h10
`define FIRST_BYTE_BITS  5'h08

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MISC_RESET       8'h00
`define MODE_RESET       8'h00
`define LFSR_SEED        6'h2d
`define PIN_IDLE         3'h4

// ----------------------------------------------------------------
// init_misc_setup field positions
// ----------------------------------------------------------------
`define MISC_RND_GATE    7
`define MISC_PARITY_EN   6
`define MISC_INT_LEVEL   5
`define MISC_INT_WIDTH   4
`define MISC_INT_HALF    3
`define MISC_DBG_EN      2

// ----------------------------------------------------------------
// target-mode codes and device mode codes
// ----------------------------------------------------------------
`define SEL_RESET        2'h0
`define SEL_INIT         2'h1
`define SEL_REPROG       2'h2
`define DEV_RESET        3'h0
`define DEV_INIT         3'h1
`define DEV_NORMAL       3'h2
`define DEV_REPROG       3'h3
`define DEV_LOWPOWER     3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ          250
`define INT_LONG_US      100
`define INT_SHORT_US     25
`define INT_LONG_CYC     (`INT_LONG_US * `CLK_MHZ)
`define INT_SHORT_CYC    (`INT_SHORT_US * `CLK_MHZ)

`endif

// ### verification/init_config_and_mode_select_asserts.sv
// port-level assertions for the init-setup and secured-mode register bank
`timescale 1ns/10ps
`include "init_cfg_defs.vh"
module init_config_and_mode_select_asserts #(
  parameter INT_LONG_CYC  = 20,              // long pulse length in cycles
  parameter INT_SHORT_CYC = 5                // short pulse length in cycles
) (
  input wire       ref_clk,                  // device clock
  input wire       rst,                      // synchronous reset
  input wire       spi_cs_n,                 // chip select pin
  input wire [2:0] dev_mode,                 // device mode
  input wire       lp_req,                   // low-power request
  input wire       lp_grant,                 // low-power accepted
  input wire       lp_deny,                  // low-power refused
  input wire       wd_half,                  // half watchdog period
  input wire       int_event,                // interrupt event
  input wire       int_ack,                  // interrupt release
  input wire [1:0] res_detect,               // detected variant
  input wire       mode_req,                 // mode change pulse
  input wire [1:0] mode_req_sel,             // mode change target
  input wire       safe_n,                   // fail-safe output
  input wire [1:0] failsafe_variant,         // variant in force
  input wire       failsafe_override,        // variant from register
  input wire       dbg_res_flag,             // mismatch flag
  input wire       int_n                     // interrupt output
);
  // ----------------------------------------------------------------
  // low-phase length of the interrupt output
  // ----------------------------------------------------------------
  reg [15:0] low_cnt_reg;
  // counts sampled low cycles, cleared while high
  always @(posedge ref_clk) begin
    low_cnt_reg <= (rst || int_n) ? 16'h0 : low_cnt_reg + 16'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst_out; $fell(rst) |-> int_n && safe_n && !mode_req && !lp_grant && !dbg_res_flag; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_lp_ans; lp_req |=> lp_grant ^ lp_deny; endproperty
  a_lp_ans: assert property (p_lp_ans) else $error("low-power request not answered once");
  property p_mode_pulse; mode_req |-> mode_req_sel != 2'h3 ##1 !mode_req; endproperty
  a_mode_pulse: assert property (p_mode_pulse) else $error("bad mode change pulse");
  property p_mode_cs; mode_req |-> spi_cs_n && $past(spi_cs_n, 3); endproperty
  a_mode_cs: assert property (p_mode_cs) else $error("mode change inside a frame");
  property p_safe_init; $fell(safe_n) |-> $past(dev_mode) == `DEV_INIT; endproperty
  a_safe_init: assert property (p_safe_init) else $error("fail-safe pin lowered outside init");
  property p_int_len;
    $rose(int_n) |-> low_cnt_reg == INT_LONG_CYC || low_cnt_reg == INT_SHORT_CYC || $past(int_ack);
  endproperty
  a_int_len: assert property (p_int_len) else $error("interrupt low phase of wrong length");
  property p_int_cause; $fell(int_n) |-> $past(int_event) || $past(wd_half); endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without a cause");
  property p_wd_mode; wd_half && !int_event && int_n && dev_mode != `DEV_REPROG |=> int_n; endproperty
  a_wd_mode: assert property (p_wd_mode) else $error("half-period pulse outside reprogram");
  property p_dbg; failsafe_override && failsafe_variant != res_detect |=> dbg_res_flag; endproperty
  a_dbg: assert property (p_dbg) else $error("mismatch flag not set");
  c_mode: cover property (mode_req);
  c_grant: cover property (lp_grant);
  c_safe: cover property ($fell(safe_n));
endmodule // init_config_and_mode_select_asserts

bind init_config_and_mode_select init_config_and_mode_select_asserts #(
  .INT_LONG_CYC(INT_LONG_CYC), .INT_SHORT_CYC(INT_SHORT_CYC)) u_chk (.ref_clk, .rst, .spi_cs_n, .dev_mode,
  .lp_req, .lp_grant, .lp_deny, .wd_half, .int_event, .int_ack, .res_detect, .mode_req, .mode_req_sel,
  .safe_n, .failsafe_variant, .failsafe_override, .dbg_res_flag, .int_n);

// ### verification/spi_host_model.sv
// host-side spi master model that frames register accesses
`timescale 1ns/10ps
module spi_host_model (
  input  wire ref_clk,                       // pacing clock
  input  wire miso_line,                     // resolved miso wire
  output reg  sclk = 1'b0,                   // spi clock, idle low
  output reg  mosi = 1'b0,                   // spi data out
  output reg  cs_n = 1'b1                    // chip select, active low
);
  reg par_on = 1'b0;                         // host computes parity when set
  // one frame of n bits, msb first; bad spoils the parity
  task xfer(input [15:0] f, input bad, input integer n, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      if (f[15:14] == 2'h1) f[8] = par_on & (^{f[15:9], f[7:0]} ^ bad);
      @(posedge ref_clk) cs_n <= 1'b0;
      for (i = 15; i > 15 - n; i = i - 1) begin
        @(posedge ref_clk) mosi <= f[i];
        repeat (8) @(posedge ref_clk);
        sclk <= 1'b1;
        if (i < 8) rd[i] = miso_line;
        repeat (8) @(posedge ref_clk);
        sclk <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      cs_n <= 1'b1;
      mosi <= ~mosi;                         // released line keeps no stale value
      repeat (12) @(posedge ref_clk);
    end
  endtask
  // secured change: read the code, then write target and inverted code
  task secure(input [1:0] sel, input part, input bad, output [5:0] code);
    reg [7:0] rd;
    begin
      xfer(16'h1300, 1'b0, 16, rd);
      code = rd[5:0];
      xfer({8'h52, sel, ~code ^ {part, part, 3'h0, bad}}, 1'b0, 16, rd);
    end
  endtask
endmodule // spi_host_model

// ### verification/tb_init_config_and_mode_select.sv
// self-checking bench for the init-setup and secured-mode register bank
`timescale 1ns/10ps
`include "init_cfg_defs.vh"
module tb_init_config_and_mode_select;
  reg        ref_clk = 0, rst = 1, lp_req = 0, wd_half = 0, int_event = 0, int_ack = 0, flag_clr = 0, last_m = 0;
  reg  [2:0] dev_mode = 0, lp_code = 0;
  reg  [1:0] res_detect = 0, sel_q = 0;
  reg  [7:0] r, v;
  reg  [5:0] c;
  reg [31:0] rnd;
  integer    bad_count = 0, compares = 0, cyc = 0, nreq = 0, ngr = 0, ndn = 0, k, n, n0;
  wire       sclk, mosi, cs_n, miso, oe_n, grant, deny, mreq, safe_n, ovr, dbg, perr, int_n;
  wire [1:0] msel, fvar;
  wire       miso_line = oe_n ? ~last_m : miso;  // undriven wire shows no stale value
  spi_host_model u_host (.ref_clk(ref_clk), .miso_line(miso_line), .sclk(sclk), .mosi(mosi), .cs_n(cs_n));
  init_config_and_mode_select #(.INT_LONG_CYC(20), .INT_SHORT_CYC(5)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_cs_n(cs_n), .spi_miso(miso), .spi_miso_oe_n(oe_n),
    .dev_mode(dev_mode), .lp_req(lp_req), .lp_code(lp_code), .lp_grant(grant), .lp_deny(deny),
    .wd_half(wd_half), .int_event(int_event), .int_ack(int_ack), .res_detect(res_detect),
    .flag_clr(flag_clr), .mode_req(mreq), .mode_req_sel(msel), .safe_n(safe_n), .failsafe_variant(fvar),
    .failsafe_override(ovr), .dbg_res_flag(dbg), .parity_err(perr), .int_n(int_n));
  // 250 mhz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // pulse counters and hang guard
  always @(posedge ref_clk) begin
    last_m <= oe_n ? last_m : miso;
    cyc <= cyc + 1;
    if (mreq === 1'b1) nreq <= nreq + 1;
    if (mreq === 1'b1) sel_q <= msel;
    if (grant === 1'b1) ngr <= ngr + 1;
    if (deny === 1'b1) ndn <= ndn + 1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d, input bad, input integer nb);
    u_host.xfer({`CMD_WRITE, a, 1'b0, d}, bad, nb, r);
  endtask
  task rdr(input [4:0] a);
    u_host.xfer({`CMD_READ, a, 9'h000}, 1'b0, 16, r);
  endtask
  // whether a secured write must be taken
  function acc(input [1:0] s, input [2:0] dm, input bad);
    acc = !bad && s != 2'h3 && (s != `SEL_INIT || dm == `DEV_NORMAL);
  endfunction
  // expected low cycles of the interrupt per case
  function [7:0] int_exp(input integer m);
    int_exp = (m == 0) ? 8'd20 : (m == 4) ? 8'd0 : 8'd5;
  endfunction
  task sec(input [1:0] s, input part, input bad);
    begin
      n0 = nreq;
      u_host.secure(s, part, bad, c);
      chk({7'h0, nreq != n0}, {7'h0, acc(s, dev_mode, bad | part)});
      if (nreq != n0) chk({6'h0, sel_q}, {6'h0, s});
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    rnd = $urandom(40395);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rdr(`ADDR_MISC);
    chk(r, `MISC_RESET);
    chk({6'h0, int_n, safe_n}, 8'h03);
    dev_mode <= `DEV_NORMAL;
    wr(`ADDR_MISC, 8'h7c, 1'b0, 16);
    rdr(`ADDR_MISC);
    chk(r, 8'h00);
    dev_mode <= `DEV_INIT;
    wr(`ADDR_MISC, 8'hff, 1'b0, 12);
    rdr(`ADDR_MISC);
    chk(r, 8'h00);
    for (k = 0; k < 8; k = k + 1) begin
      rnd = $urandom;
      v = (rnd[7:0] & 8'hb8) | k[7:0];
      res_detect <= rnd[9:8];
      wr(`ADDR_MISC, v, 1'b0, 16);
      rdr(`ADDR_MISC);
      chk(r, v);
      chk({7'h0, ovr}, {7'h0, v[2]});
      if (v[2]) chk({6'h0, fvar}, {6'h0, v[1:0]});
      else chk({6'h0, fvar}, {6'h0, rnd[9:8]});
      if (v[2] && rnd[9:8] != v[1:0]) chk({7'h0, dbg}, 8'h01);
      @(posedge ref_clk) flag_clr <= 1'b1;
      @(posedge ref_clk) flag_clr <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({7'h0, dbg}, {7'h0, v[2] && rnd[9:8] != v[1:0]});
    end
    for (k = 0; k < 5; k = k + 1) begin
      dev_mode <= `DEV_INIT;
      wr(`ADDR_MISC, (k == 2) ? 8'h20 : (k > 2) ? 8'h18 : {3'h0, k[0], 4'h0}, 1'b0, 16);
      dev_mode <= (k == 3) ? `DEV_REPROG : (k == 4) ? `DEV_NORMAL : `DEV_INIT;
      @(posedge ref_clk) int_event <= (k < 3);
      wd_half <= (k > 2);
      @(posedge ref_clk) int_event <= 1'b0;
      wd_half <= 1'b0;
      n = 0;
      for (n0 = 0; n0 < 60; n0 = n0 + 1) begin
        @(posedge ref_clk) int_ack <= (k == 2 && n0 == 30);
        n = n + (int_n === 1'b0);
      end
      if (k == 2) chk({7'h0, n > 27 && n < 34}, 8'h01);
      else chk(n[7:0], int_exp(k));
    end
    dev_mode <= `DEV_INIT;
    wr(`ADDR_MISC, 8'h40, 1'b0, 16);
    u_host.par_on = 1'b1;
    wr(`ADDR_MISC, 8'h47, 1'b1, 16);
    chk({7'h0, perr}, 8'h01);
    rdr(`ADDR_MISC);
    chk(r, 8'h40);
    wr(`ADDR_MISC, 8'h80, 1'b0, 16);
    chk({7'h0, perr}, 8'h00);
    u_host.par_on = 1'b0;
    for (k = 0; k < 3; k = k + 1) begin
      if (k == 2) wr(`ADDR_MISC, 8'h00, 1'b0, 16);
      rdr(`ADDR_MODE);
      c = r[5:0];
      rnd = $urandom;
      lp_code <= (k == 0) ? ~c[2:0] ^ (rnd[2:0] | 3'h1) : (k == 1) ? ~c[2:0] : rnd[2:0];
      n0 = ngr;
      n = ndn;
      @(posedge ref_clk) lp_req <= 1'b1;
      @(posedge ref_clk) lp_req <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({7'h0, ngr != n0}, {7'h0, k > 0});
      chk({7'h0, ndn != n}, {7'h0, k == 0});
    end
    dev_mode <= `DEV_NORMAL;
    sec(`SEL_INIT, 1'b0, 1'b0);
    sec(`SEL_INIT, 1'b0, 1'b1);
    sec(`SEL_INIT, 1'b1, 1'b0);
    for (k = 0; k < 8; k = k + 1) begin
      rnd = $urandom;
      dev_mode <= (rnd[1:0] == 2'h0) ? `DEV_INIT : {1'b0, rnd[1:0]};
      sec(k[1:0], 1'b0, 1'b0);
    end
    dev_mode <= `DEV_INIT;
    chk({7'h0, safe_n}, 8'h01);
    sec(`SEL_INIT, 1'b1, 1'b0);
    chk({7'h0, safe_n}, 8'h00);
    // mid-run reset clears the written setup and the fail-safe pin
    wr(`ADDR_MISC, 8'h18, 1'b0, 16);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rdr(`ADDR_MISC);
    chk(r, `MISC_RESET);
    chk({6'h0, int_n, safe_n}, 8'h03);
    wrap_up;
  end
endmodule // tb_init_config_and_mode_select
